// *** core/jrr_pkg.sv ***
// Purpose: shared constants for the register-jump redirect block
// Assumes: 32-bit instruction words, 64-bit general registers
// Notes:   field positions and opcodes are named here, never bare in logic
`default_nettype none
package jrr_pkg;
    // ------------------------------------------------------------
    // instruction fields
    // ------------------------------------------------------------
    localparam int unsigned OP_HI     = 31;
    localparam int unsigned OP_LO     = 26;
    localparam int unsigned FUNCT_HI  = 5;
    localparam int unsigned FUNCT_LO  = 0;
    localparam int unsigned SRC_HI    = 25;
    localparam int unsigned SRC_LO    = 21;
    localparam int unsigned INDEX_HI  = 25;
    localparam int unsigned INDEX_LO  = 0;
    localparam int unsigned BARRIER_B = 10;
    localparam int unsigned REGION_LO = 28;
    localparam int unsigned INDEX_W   = 26;

    // ------------------------------------------------------------
    // encodings
    // ------------------------------------------------------------
    localparam logic [5:0] MAJOR_GROUP_OP = 6'h00;
    localparam logic [5:0] REG_JUMP_FUNCT = 6'h08;
    localparam logic [5:0] REGION_JX_OP   = 6'h1D;
    localparam logic [1:0] ALIGN_ZERO     = 2'h0;
    localparam logic [1:0] HALF_MISALIGN  = 2'h2;
    localparam logic [2:0] WORD_BYTES     = 3'h4;

    // ------------------------------------------------------------
    // sequencer states, one-hot
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        JRR_IDLE      = 2'b01,
        JRR_WAIT_SLOT = 2'b10
    } jrr_state_t;
endpackage
`default_nettype wire

// *** core/jrr_target_calc.sv ***
// Purpose: combinational jump target and mode computation
// Assumes: src_data was read in the jump's own cycle
// Notes:   alignment fault is only computed here, raised later at fetch
`default_nettype none
module jrr_target_calc
    import jrr_pkg::*;
#(
    parameter int unsigned GPRLEN = 64
) (
    input  wire logic [31:0]       instr,
    input  wire logic [GPRLEN-1:0] src_data,
    input  wire logic [GPRLEN-1:0] slot_pc,
    input  wire logic              compressed_isa_present,
    input  wire logic              isa_mode,
    input  wire logic              is_region,
    output logic      [GPRLEN-1:0] target,
    output logic                   target_mode,
    output logic                   target_misaligned
);
    // ------------------------------------------------------------
    // target forming
    // ------------------------------------------------------------
    wire logic [GPRLEN-1:0] region_tgt;
    wire logic [GPRLEN-1:0] reg_tgt;
    wire logic              reg_mode;

    // upper bits from the delay slot address, so the last word of a region
    // lands in the next region
    assign region_tgt = {slot_pc[GPRLEN-1:REGION_LO], instr[INDEX_HI:INDEX_LO], ALIGN_ZERO};
    // bit zero dropped into the mode bit when a compressed set exists
    assign reg_tgt  = compressed_isa_present ? {src_data[GPRLEN-1:1], 1'b0} : src_data;
    assign reg_mode = compressed_isa_present ? src_data[0] : isa_mode;

    assign target      = is_region ? region_tgt : reg_tgt;
    assign target_mode = is_region ? ~isa_mode : reg_mode;

    // with a compressed set bit zero is already cleared, so it alone never faults
    // full word alignment without a compressed set else 1-0 pattern
    assign target_misaligned = is_region ? 1'b0 :
                               compressed_isa_present ? (reg_tgt[1:0] == HALF_MISALIGN) :
                                                        (reg_tgt[1:0] != ALIGN_ZERO);
endmodule
`default_nettype wire

// *** core/jrr_redirect.sv ***
// Purpose: program counter redirect for register and region jumps
// Assumes: decode presents one instruction per issue_valid pulse
// Notes:   redirect waits for the delay slot to issue; outputs are flops
//          one jump in flight; a jump offered while busy is dropped
`default_nettype none
// Function
// - region target: upper PC, index, two zeros
// - region jump inverts instruction set select
// - upper bits taken from delay slot address
// - delay slot executes before target fetch
// - register read at jump, PC applied later
// - compressed set: clear bit zero, copy mode
// - compressed set: register bit zero never faults alone
// - no compressed set: low bits fault at fetch
// - compressed set: pattern 1-0 faults at fetch
// - decode group 000000, funct 001000, bit10 barrier
// - barrier clears hazards from target fetch on
// - barrier accepted in every operating mode
// - delay slot hazards stay uncleared
// - only barrier, exception return or reset clear
module jrr_redirect
    import jrr_pkg::*;
#(
    parameter int unsigned GPRLEN = 64
) (
    input  wire logic              clk,
    input  wire logic              rst_n,
    input  wire logic              issue_valid,
    input  wire logic [31:0]       issue_instr,
    input  wire logic [GPRLEN-1:0] issue_pc,
    input  wire logic [GPRLEN-1:0] src_reg_data,
    input  wire logic              slot_issue,
    input  wire logic              compressed_isa_present,
    input  wire logic              hazard_raise,
    input  wire logic              exception_return_clear,
    output logic      [4:0]        src_reg_addr,
    output logic                   redirect_valid,
    output logic      [GPRLEN-1:0] redirect_pc,
    output logic                   flush_seq,
    output logic                   fetch_addr_err,
    output logic                   instruction_set_select,
    output logic                   hazard_clear_action,
    output logic                   hazard_pending,
    output logic                   jump_busy
);
    // ------------------------------------------------------------
    // decode
    // ------------------------------------------------------------
    wire logic              is_reg_jump;
    wire logic              is_region;
    wire logic              is_barrier;
    wire logic              take_jump;
    wire logic [GPRLEN-1:0] slot_pc;
    wire logic [GPRLEN-1:0] calc_target;
    wire logic              calc_mode;
    wire logic              calc_misaligned;

    // limitation: neither the zero field above the hint nor the low hint bits
    // are checked, so a malformed word still jumps; the trade is a smaller
    // decoder against having no reserved-instruction path in this block,
    // which is left to the main decoder
    // any hint is accepted; zero is default handling, bit 10 marks the barrier.
    // no privilege input exists, so the barrier is legal in all modes
    assign is_reg_jump = (issue_instr[OP_HI:OP_LO] == MAJOR_GROUP_OP) &&
                         (issue_instr[FUNCT_HI:FUNCT_LO] == REG_JUMP_FUNCT);
    assign is_region   = (issue_instr[OP_HI:OP_LO] == REGION_JX_OP);
    assign is_barrier  = is_reg_jump && issue_instr[BARRIER_B];
    // delay slot address; its upper bits give the region target
    assign slot_pc     = issue_pc + GPRLEN'(WORD_BYTES);

    // sequencer state, one-hot
    jrr_state_t state_reg;
    jrr_state_t state_next;

    // a jump in a delay slot is unpredictable, so it is simply ignored
    assign take_jump = issue_valid && (is_reg_jump || is_region) && (state_reg == JRR_IDLE);

    // target, mode and alignment worked out from the jump cycle's operands
    jrr_target_calc #(
        .GPRLEN(GPRLEN)
    ) jrr_target_calc_inst (
        .instr                  (issue_instr),
        .src_data               (src_reg_data),
        .slot_pc                (slot_pc),
        .compressed_isa_present (compressed_isa_present),
        .isa_mode               (instruction_set_select),
        .is_region              (is_region),
        .target                 (calc_target),
        .target_mode            (calc_mode),
        .target_misaligned      (calc_misaligned)
    );

    // ------------------------------------------------------------
    // held jump state
    // ------------------------------------------------------------
    // one jump in flight: its target, mode, fault and barrier flag wait here
    logic [GPRLEN-1:0] tgt_reg;
    logic              mode_reg;
    logic              misal_reg;
    logic              barrier_reg;
    logic              older_haz_reg;
    logic              slot_haz_reg;

    // the slot's issue releases the held jump; a stalled slot just waits
    wire logic redirect_now;
    assign redirect_now = (state_reg == JRR_WAIT_SLOT) && slot_issue;

    // sequencer: wait for the delay slot, then steer fetch
    always_comb begin
        state_next = state_reg;
        unique case (state_reg)
            JRR_IDLE:      if (take_jump) state_next = JRR_WAIT_SLOT;
            JRR_WAIT_SLOT: if (slot_issue) state_next = JRR_IDLE;
            default:       state_next = JRR_IDLE;
        endcase
    end

    // target captured in the jump cycle, so a slot write cannot move it
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            state_reg   <= JRR_IDLE;
            tgt_reg     <= '0;
            mode_reg    <= 1'b0;
            misal_reg   <= 1'b0;
            barrier_reg <= 1'b0;
        end else begin
            state_reg <= state_next;
            if (take_jump) begin
                tgt_reg     <= calc_target;
                mode_reg    <= calc_mode;
                misal_reg   <= calc_misaligned;
                barrier_reg <= is_barrier;
            end
        end
    end

    // ------------------------------------------------------------
    // hazard tracking
    // ------------------------------------------------------------
    // two trackers: older hazards, which a barrier clears, and slot hazards,
    // which only age into older ones once the redirect has gone by
    wire logic barrier_fire;
    wire logic slot_phase;
    wire logic slot_to_older;
    wire logic older_next;
    wire logic slot_next;
    wire logic pending_next;

    assign barrier_fire = redirect_now && barrier_reg;
    assign slot_phase   = (state_reg == JRR_WAIT_SLOT);
    // hazards raised in the slot, the redirect cycle included, join the older
    // ones after the barrier has passed, so it never clears them
    assign slot_to_older = redirect_now && (slot_haz_reg || hazard_raise);
    // older hazards cleared by a barrier or exception return; a raise in that
    // same cycle from outside the slot survives, since set beats clear
    assign older_next = (hazard_raise && !slot_phase) ||
                        (older_haz_reg && !barrier_fire && !exception_return_clear) ||
                        slot_to_older;
    // slot hazards are kept apart while the jump waits
    assign slot_next  = slot_phase && !redirect_now && (slot_haz_reg || hazard_raise);
    // pending mirrors the next state of both trackers so it is a plain flop
    assign pending_next = older_next || slot_next;

    // hazard trackers
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            older_haz_reg <= 1'b0;
            slot_haz_reg  <= 1'b0;
        end else begin
            older_haz_reg <= older_next;
            slot_haz_reg  <= slot_next;
        end
    end

    // ------------------------------------------------------------
    // registered outputs toward fetch
    // ------------------------------------------------------------
    // redirect, flush and fault appear together so the fault lands on the
    // target fetch, not on the jump
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            redirect_valid <= 1'b0;
            flush_seq      <= 1'b0;
            fetch_addr_err <= 1'b0;
        end else begin
            redirect_valid <= redirect_now;
            flush_seq      <= redirect_now;
            fetch_addr_err <= redirect_now && misal_reg;
        end
    end

    // target and mode change only on a redirect and hold until the next one;
    // the mode bit feeds back into the calculator for region jumps
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            redirect_pc            <= '0;
            instruction_set_select <= 1'b0;
        end else if (redirect_now) begin
            redirect_pc            <= tgt_reg;
            instruction_set_select <= mode_reg;
        end
    end

    // ------------------------------------------------------------
    // registered status toward decode and register file
    // ------------------------------------------------------------
    // barrier clearing shows with the redirect, so fetch and decode of the
    // target see clean state
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            hazard_clear_action <= 1'b0;
            hazard_pending      <= 1'b0;
            jump_busy           <= 1'b0;
            src_reg_addr        <= '0;
        end else begin
            hazard_clear_action <= barrier_fire;
            hazard_pending      <= pending_next;
            jump_busy           <= (state_next == JRR_WAIT_SLOT);
            src_reg_addr        <= issue_instr[SRC_HI:SRC_LO];
        end
    end
endmodule
`default_nettype wire

// *** verification/jrr_redirect_props.sv ***
// Purpose: port-level checks on the register-jump redirect block
// Assumes: single clock, async active-low reset
// Notes:   the compressed flag is a level, so it is taken as steady around a redirect
`default_nettype none
module jrr_redirect_props
    import jrr_pkg::*;
#(
    parameter int unsigned GPRLEN = 64
) (
    input wire logic              clk,
    input wire logic              rst_n,
    input wire logic              issue_valid,
    input wire logic [31:0]       issue_instr,
    input wire logic [GPRLEN-1:0] issue_pc,
    input wire logic [GPRLEN-1:0] src_reg_data,
    input wire logic              slot_issue,
    input wire logic              compressed_isa_present,
    input wire logic              hazard_raise,
    input wire logic              exception_return_clear,
    input wire logic [4:0]        src_reg_addr,
    input wire logic              redirect_valid,
    input wire logic [GPRLEN-1:0] redirect_pc,
    input wire logic              flush_seq,
    input wire logic              fetch_addr_err,
    input wire logic              instruction_set_select,
    input wire logic              hazard_clear_action,
    input wire logic              hazard_pending,
    input wire logic              jump_busy
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);
    // decode and sequencing
    busy_on_jump_a: assert property (issue_valid && !jump_busy &&
        issue_instr[OP_HI:OP_LO] == MAJOR_GROUP_OP &&
        issue_instr[FUNCT_HI:FUNCT_LO] == REG_JUMP_FUNCT |=> jump_busy)
        else $error("jump not taken");
    slot_then_go_a: assert property (jump_busy && slot_issue |=> redirect_valid)
        else $error("no redirect after slot");
    redir_cause_a: assert property (redirect_valid |->
        $past(slot_issue) && $past(jump_busy)) else $error("redirect without slot");
    flush_pair_a: assert property (flush_seq == redirect_valid)
        else $error("flush apart from redirect");
    pc_hold_a: assert property (!redirect_valid |-> $stable(redirect_pc))
        else $error("target moved");
    mode_hold_a: assert property (!redirect_valid |-> $stable(instruction_set_select))
        else $error("mode moved");
    // target shape and fault timing
    bit0_clear_a: assert property (redirect_valid && compressed_isa_present |->
        !redirect_pc[0]) else $error("bit zero kept");
    ca_fault_a: assert property (redirect_valid && compressed_isa_present |->
        fetch_addr_err == (redirect_pc[1:0] == HALF_MISALIGN)) else $error("fault pattern");
    plain_fault_a: assert property (redirect_valid && !compressed_isa_present |->
        fetch_addr_err == (redirect_pc[1:0] != ALIGN_ZERO)) else $error("fault pattern");
    fault_at_fetch_a: assert property (fetch_addr_err |-> redirect_valid)
        else $error("fault off fetch");
    clear_at_fetch_a: assert property (hazard_clear_action |-> redirect_valid)
        else $error("clear off fetch");
endmodule
bind jrr_redirect jrr_redirect_props #(.GPRLEN(GPRLEN)) jrr_redirect_props_inst (.clk(clk),
    .rst_n(rst_n), .issue_valid(issue_valid), .issue_instr(issue_instr), .issue_pc(issue_pc),
    .src_reg_data(src_reg_data), .slot_issue(slot_issue), .hazard_raise(hazard_raise),
    .compressed_isa_present(compressed_isa_present), .src_reg_addr(src_reg_addr),
    .exception_return_clear(exception_return_clear), .redirect_valid(redirect_valid),
    .redirect_pc(redirect_pc), .flush_seq(flush_seq), .fetch_addr_err(fetch_addr_err),
    .instruction_set_select(instruction_set_select), .hazard_pending(hazard_pending),
    .hazard_clear_action(hazard_clear_action), .jump_busy(jump_busy));
`default_nettype wire

// *** verification/jrr_far_model.sv ***
// Purpose: register file and fetch stage facing the redirect block
// Assumes: writes land on the rising edge
// Notes:   unwritten registers read unknown, no kinder than real storage
`default_nettype none
module jrr_far_model
    import jrr_pkg::*;
(
    input  wire logic        clk,
    input  wire logic        wr_en,
    input  wire logic [4:0]  wr_addr,
    input  wire logic [63:0] wr_data,
    input  wire logic [31:0] rd_instr,
    input  wire logic        redirect_valid,
    input  wire logic [63:0] redirect_pc,
    output logic      [63:0] rd_data,
    output var logic  [63:0] fetch_pc
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [63:0] regs [32];
    // read is combinational so the value is there in the jump's own cycle
    assign rd_data = regs[rd_instr[SRC_HI:SRC_LO]];
    // fetch moves only on a redirect; writes from the slot land afterwards
    always_ff @(posedge clk) begin
        if (wr_en) begin
            regs[wr_addr] <= wr_data;
        end
        if (redirect_valid) begin
            fetch_pc <= redirect_pc;
        end
    end
endmodule
`default_nettype wire

// *** verification/jrr_redirect_tb_top.sv ***
// Purpose: directed bench for the register-jump redirect block
// Assumes: inputs change 1 ns after the rising edge
// Notes:   each jump issued through jmp has its source register overwritten right after issue
`default_nettype none
module jrr_redirect_tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    import jrr_pkg::*;
    logic        clk = 0, rst_n = 0, iv = 0, si = 0, ca = 0, hr = 0, erc = 0, we = 0;
    logic [31:0] ins = '0;
    logic [63:0] ipc = '0, wd = '0, rdd, fpc, rpc;
    logic [4:0]  wa = '0, sra;
    logic        rv, fl, fe, mode, hca, hp, busy;
    int          err_count = 0, checked = 0;
    always #12.5 clk = ~clk;
    jrr_far_model jrr_far_model_inst (.clk(clk), .wr_en(we), .wr_addr(wa), .wr_data(wd),
        .rd_instr(ins), .redirect_valid(rv), .redirect_pc(rpc), .rd_data(rdd), .fetch_pc(fpc));
    jrr_redirect #(.GPRLEN(64)) jrr_redirect_inst (.clk(clk), .rst_n(rst_n), .issue_valid(iv),
        .issue_instr(ins), .issue_pc(ipc), .src_reg_data(rdd), .slot_issue(si),
        .compressed_isa_present(ca), .hazard_raise(hr), .exception_return_clear(erc),
        .src_reg_addr(sra), .redirect_valid(rv), .redirect_pc(rpc), .flush_seq(fl),
        .fetch_addr_err(fe), .instruction_set_select(mode), .hazard_clear_action(hca),
        .hazard_pending(hp), .jump_busy(busy));
    task automatic tick();
        @(posedge clk);
        #1;
    endtask
    task automatic cmp(input logic ok, input string m);
        checked++;
        if (ok !== 1'b1) begin
            err_count++;
            $display("unexpected at %0t: %s", $time, m);
        end
    endtask
    task automatic report_and_stop();
        $display("errors %0d checks %0d", err_count, checked);
        if (err_count == 0 && checked > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask
    function automatic logic [31:0] rjump(input logic [4:0] r, input logic b);
        return {MAJOR_GROUP_OP, r, 10'h000, b, 4'h0, REG_JUMP_FUNCT};
    endfunction
    // load the register, issue, overwrite it as the slot would, then judge the redirect
    task automatic jmp(input logic [31:0] i, input logic [63:0] pc, d, ep,
                       input logic em, ee, ec, sh);
        we = 1;
        wa = i[SRC_HI:SRC_LO];
        wd = d;
        tick();
        iv = 1;
        ins = i;
        ipc = pc;
        wd = ~d;
        tick();
        cmp(busy === 1'b1 && sra === i[SRC_HI:SRC_LO], "wait for slot");
        iv = 0; // the slot carries no jump
        we = 0;
        si = 1;
        hr = sh;
        tick();
        si = 0;
        hr = 0;
        cmp(rv === 1'b1 && fl === 1'b1 && rpc === ep && busy === 1'b0,
            "target");
        cmp(mode === em && fe === ee && hca === ec,
            "mode, fault or clear");
        tick();
        cmp(rv === 1'b0 && fpc === ep, "fetch");
    endtask
    // older hazards go with a barrier, slot hazards survive it; software
    // runs a barrier before relying on the cleared state
    task automatic hz();
        hr = 1;
        tick();
        hr = 0;
        jmp(rjump(5'h08, 1'b0), 64'h0, 64'h40, 64'h40,
            1'b0, 1'b0, 1'b0, 1'b0);
        cmp(hp === 1'b1, "plain jump cleared hazard");
        jmp(rjump(5'h08, 1'b1), 64'h0, 64'h80, 64'h80,
            1'b0, 1'b0, 1'b1, 1'b0);
        cmp(hp === 1'b0, "barrier left hazard");
        jmp(rjump(5'h08, 1'b1), 64'h0, 64'hC0, 64'hC0,
            1'b0, 1'b0, 1'b1, 1'b1);
        cmp(hp === 1'b1, "slot hazard cleared");
        erc = 1;
        hr = 1;
        tick();
        hr = 0;
        cmp(hp === 1'b1, "raise lost to clear");
        tick();
        erc = 0;
        cmp(hp === 1'b0, "return left hazard");
    endtask
    // neighbouring function code must not start a jump
    task automatic refuse();
        iv = 1;
        ins = rjump(5'h08, 1'b0) ^ 32'h0000_0001;
        tick();
        iv = 0;
        cmp(busy === 1'b0, "non-jump taken");
    endtask
    // a reset in mid-run drops a waiting jump and all hazards, then works again
    task automatic rst_mid();
        iv = 1;
        ins = rjump(5'h08, 1'b0);
        hr = 1;
        tick();
        iv = 0;
        hr = 0;
        cmp(busy === 1'b1 && hp === 1'b1 && rpc !== '0, "state before reset");
        rst_n = 0;
        #1;
        cmp(rv === 1'b0 && fl === 1'b0 && fe === 1'b0 && hca === 1'b0 && hp === 1'b0 &&
            busy === 1'b0 && mode === 1'b0 && rpc === '0 && sra === '0, "reset");
        repeat (2) tick();
        rst_n = 1;
        jmp(rjump(5'h08, 1'b0), 64'h0, 64'h44, 64'h44,
            1'b0, 1'b0, 1'b0, 1'b0);
    endtask
    initial begin
        repeat (20) @(posedge clk);
        #1;
        rst_n = 1;
        tick();
        refuse();
        jmp(rjump(5'h08, 1'b0), 64'h400000, 64'h0123_4567_89AB_CDE0, 64'h0123_4567_89AB_CDE0,
            1'b0, 1'b0, 1'b0, 1'b0);
        jmp(rjump(5'h1F, 1'b0), 64'h0, 64'h1001, 64'h1001,
            1'b0, 1'b1, 1'b0, 1'b0);
        ca = 1;
        jmp(rjump(5'h09, 1'b0), 64'h0, 64'h2001, 64'h2000,
            1'b1, 1'b0, 1'b0, 1'b0);
        jmp(rjump(5'h09, 1'b0), 64'h0, 64'h3002, 64'h3002,
            1'b0, 1'b1, 1'b0, 1'b0);
        jmp({REGION_JX_OP, 26'h000_0001}, 64'h0FFF_FFFC, 64'h0, 64'h1000_0004,
            1'b1, 1'b0, 1'b0, 1'b0);
        jmp({REGION_JX_OP, 26'h3FF_FFFF}, 64'h2000_0000, 64'h0, 64'h2FFF_FFFC,
            1'b0, 1'b0, 1'b0, 1'b0);
        ca = 0;
        hz();
        rst_mid();
        report_and_stop();
    end
    // a hang ends the run through the same closing task
    initial begin
        #(25 * 1000);
        err_count++;
        report_and_stop();
    end
endmodule
`default_nettype wire
